/* File: verilog/pps_pkg.sv */
// Constants, carrier types and state codes for the protection sequencer.
// Assumes one 200 MHz core clock; all analogue decisions arrive as comparator bits.
package pps_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and debounce timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int OVP_DB_NS = 50000;
  localparam int FB_OPEN_DB_NS = 1800;
  localparam int CS_OPEN_DB_NS = 10000;
  // Least times: round up to whole cycles
  localparam int OVP_DB_CYC = (OVP_DB_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FB_OPEN_DB_CYC = (FB_OPEN_DB_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CS_OPEN_DB_CYC = (CS_OPEN_DB_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Startup check lasts long enough for both open-path debouncers to finish
  localparam int CHECK_CYC = 2 * CS_OPEN_DB_CYC;
  localparam int CNT_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Debouncer slots
  localparam int DB_OVP = 0;
  localparam int DB_FB_OPEN = 1;
  localparam int DB_CS_OPEN = 2;
  localparam int DB_N = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Comparator results, each high while its condition is true
  typedef struct packed {
    logic fb_over;       // feedback above feedback_over_level (reference +7%)
    logic fb_release;    // feedback below feedback_release_level
    logic fb_open;       // feedback below feedback_open_level
    logic cs_peak;       // sense below peak_limit_level
    logic cs_sat;        // sense below saturation_level
    logic cs_zero;       // sense at zero_current_level
    logic cs_open;       // sense above sense_open_level
    logic vcc_on;        // supply at or above supply_turn_on_level
    logic vcc_off;       // supply at or below supply_turn_off_level
    logic vcc_recharge;  // supply below supply_recharge_level
    logic line_high;     // line_sense_input above the feedforward threshold
  } pps_cmp_type;

  typedef struct packed {
    logic hv_startup;
    logic low_power;
    logic soft_start;
    logic gain_high;
    logic ovp_active;
    logic sat_active;
    logic fb_fault;
    logic cs_fault;
  } pps_status_type;

  typedef enum logic [6:0] {
    PPS_OFF = 7'h01,
    PPS_CHECK = 7'h02,
    PPS_RUN = 7'h04,
    PPS_OVP = 7'h08,
    PPS_SAT = 7'h10,
    PPS_FB_OPEN = 7'h20,
    PPS_CS_FAIL = 7'h40
  } pps_state_type;

endpackage : pps_pkg

/* File: verilog/pps_protection_sequencer.sv */
// Protection and fault sequencer for a boost power-factor controller.
// Assumes comparator bits arrive asynchronously and i_pwm_on comes from the
// modulator on i_core_clk.
//
// Overview of operation
// [R1] Overvoltage_guard stops switching on feedback over the over level and holds until release.
// [R2] The overvoltage indication must persist 50 us before it is acted on.
// [R3] During an overvoltage stop the startup source turns on below the recharge level until turn-on.
// [R4] Peak_current_limit ends the on-time early when sense falls below the peak limit level.
// [R5] Saturation_guard stops all switching when saturation is seen in two consecutive cycles.
// [R6] After a saturation stop switching resumes only once sense reaches the zero-current level.
// [R7] At turn-on a feedback below the open level means an open divider: stop and go low power.
// [R8] The open-feedback indication must persist 1.8 us before it acts.
// [R9] At turn-on a sense above the open level means a failed sense path: stop and go low power.
// [R10] After a sense-path fault, restart needs a supply fall to turn-off and rise to turn-on.
// [R11] The sense-open indication must persist 10 us before it acts.
// [R12] One line comparison selects one of two multiplier gain settings.
// [R13] At supply turn-off the block shuts down, recharges to turn-on and restarts with soft-start.
// [R14] Every comparator is synchronised and every debounce counter restarts when its cause drops.

`timescale 1ns/1ps

module pps_protection_sequencer #(
  parameter int OVP_DB_CYCLES = pps_pkg::OVP_DB_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire pps_pkg::pps_cmp_type i_cmp,
  input wire logic i_pwm_on,
  output logic o_gate_drive,
  output pps_pkg::pps_status_type o_status
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  pps_pkg::pps_cmp_type cmp_meta;
  pps_pkg::pps_cmp_type cmp_s;
  pps_pkg::pps_state_type state;
  pps_pkg::pps_state_type next_state;
  logic [pps_pkg::DB_N-1:0] db_cond;
  logic [pps_pkg::DB_N-1:0] db_done;
  logic [pps_pkg::CNT_W-1:0] db_cnt [pps_pkg::DB_N];
  logic [pps_pkg::CNT_W-1:0] chk_cnt;
  logic pwm_d;
  logic peak_cut;
  logic sat_now;
  logic sat_prev;
  logic sat_trip;
  logic cycle_end;

  function automatic logic [pps_pkg::CNT_W-1:0] db_limit(input int idx);
    logic [pps_pkg::CNT_W-1:0] lim;
    lim = pps_pkg::CNT_W'(pps_pkg::CS_OPEN_DB_CYC);
    if (idx == pps_pkg::DB_OVP) begin
      lim = pps_pkg::CNT_W'(OVP_DB_CYCLES);
    end else if (idx == pps_pkg::DB_FB_OPEN) begin
      lim = pps_pkg::CNT_W'(pps_pkg::FB_OPEN_DB_CYC);
    end
    return lim;
  endfunction : db_limit

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchroniser; only the second stage is read
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cmp_meta <= '0;
      cmp_s <= '0;
    end else begin
      cmp_meta <= i_cmp; // R14
      cmp_s <= cmp_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Debouncers: a glitch shorter than the interval never reaches the FSM
  assign db_cond[pps_pkg::DB_OVP] = cmp_s.fb_over;
  assign db_cond[pps_pkg::DB_FB_OPEN] = cmp_s.fb_open;
  assign db_cond[pps_pkg::DB_CS_OPEN] = cmp_s.cs_open;

  for (genvar g = 0; g < pps_pkg::DB_N; g++) begin : g_db
    always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
        db_cnt[g] <= '0;
      end else if (!db_cond[g]) begin
        db_cnt[g] <= '0; // R14
      end else if (db_cnt[g] != db_limit(g)) begin
        db_cnt[g] <= db_cnt[g] + 16'h0001;
      end
    end
    assign db_done[g] = db_cond[g] && (db_cnt[g] == db_limit(g)); // R2 R8 R11
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switching-cycle tracking
  assign cycle_end = pwm_d && !i_pwm_on;
  assign sat_trip = i_pwm_on && cmp_s.cs_sat && sat_prev; // R5

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pwm_d <= 1'b0;
    end else begin
      pwm_d <= i_pwm_on;
    end
  end

  // Latched so a sense that bounces back cannot re-open the switch in the same on-time
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      peak_cut <= 1'b0;
    end else if (!i_pwm_on) begin
      peak_cut <= 1'b0;
    end else if (cmp_s.cs_peak) begin
      peak_cut <= 1'b1; // R4
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      sat_now <= 1'b0;
    end else if (cycle_end) begin
      sat_now <= 1'b0;
    end else if (i_pwm_on && cmp_s.cs_sat) begin
      sat_now <= 1'b1;
    end
  end

  // A clean cycle breaks the run of saturated cycles
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      sat_prev <= 1'b0;
    end else if (state != pps_pkg::PPS_RUN) begin
      sat_prev <= 1'b0;
    end else if (cycle_end) begin
      sat_prev <= sat_now; // R5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Startup check window
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      chk_cnt <= '0;
    end else if (state != pps_pkg::PPS_CHECK) begin
      chk_cnt <= '0;
    end else if (chk_cnt != pps_pkg::CNT_W'(pps_pkg::CHECK_CYC)) begin
      chk_cnt <= chk_cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer; supply loss outranks every other condition
  always_comb begin
    next_state = state;
    if (cmp_s.vcc_off) begin
      next_state = pps_pkg::PPS_OFF; // R13
    end else begin
      unique case (state)
        pps_pkg::PPS_OFF: begin
          if (cmp_s.vcc_on) begin
            next_state = pps_pkg::PPS_CHECK; // R10 R13
          end
        end
        pps_pkg::PPS_CHECK: begin
          if (db_done[pps_pkg::DB_FB_OPEN]) begin
            next_state = pps_pkg::PPS_FB_OPEN; // R7
          end else if (db_done[pps_pkg::DB_CS_OPEN]) begin
            next_state = pps_pkg::PPS_CS_FAIL; // R9
          end else if (chk_cnt == pps_pkg::CNT_W'(pps_pkg::CHECK_CYC)) begin
            next_state = pps_pkg::PPS_RUN;
          end
        end
        pps_pkg::PPS_RUN: begin
          if (sat_trip) begin
            next_state = pps_pkg::PPS_SAT; // R5
          end else if (db_done[pps_pkg::DB_OVP]) begin
            next_state = pps_pkg::PPS_OVP; // R1
          end
        end
        pps_pkg::PPS_OVP: begin
          if (cmp_s.fb_release) begin
            next_state = pps_pkg::PPS_RUN; // R1
          end
        end
        pps_pkg::PPS_SAT: begin
          if (cmp_s.cs_zero) begin
            next_state = pps_pkg::PPS_RUN; // R6
          end
        end
        pps_pkg::PPS_FB_OPEN: begin
          // Resumes without soft-start once feedback recovers
          if (!cmp_s.fb_open) begin
            next_state = pps_pkg::PPS_RUN;
          end
        end
        pps_pkg::PPS_CS_FAIL: begin
          next_state = pps_pkg::PPS_CS_FAIL; // R10
        end
        default: begin
          next_state = pps_pkg::PPS_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state <= pps_pkg::PPS_OFF;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all registered
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_gate_drive <= 1'b0;
    end else begin
      o_gate_drive <= (state == pps_pkg::PPS_RUN) && (next_state == pps_pkg::PPS_RUN) &&
                      i_pwm_on && !peak_cut && !cmp_s.cs_peak; // R4
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_status.hv_startup <= 1'b1;
    end else if (next_state == pps_pkg::PPS_OFF) begin
      o_status.hv_startup <= 1'b1; // R13
    end else if (next_state == pps_pkg::PPS_OVP && cmp_s.vcc_recharge) begin
      o_status.hv_startup <= 1'b1; // R3
    end else if (cmp_s.vcc_on || next_state != pps_pkg::PPS_OVP) begin
      o_status.hv_startup <= 1'b0; // R3
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_status.low_power <= 1'b0;
      o_status.fb_fault <= 1'b0;
      o_status.cs_fault <= 1'b0;
    end else begin
      o_status.low_power <= next_state inside {pps_pkg::PPS_FB_OPEN, pps_pkg::PPS_CS_FAIL};
      o_status.fb_fault <= next_state == pps_pkg::PPS_FB_OPEN; // R7
      o_status.cs_fault <= next_state == pps_pkg::PPS_CS_FAIL; // R9
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_status.ovp_active <= 1'b0;
      o_status.sat_active <= 1'b0;
      o_status.soft_start <= 1'b0;
    end else begin
      o_status.ovp_active <= next_state == pps_pkg::PPS_OVP;
      o_status.sat_active <= next_state == pps_pkg::PPS_SAT;
      o_status.soft_start <= (state == pps_pkg::PPS_CHECK) &&
                             (next_state == pps_pkg::PPS_RUN); // R13
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_status.gain_high <= 1'b0;
    end else begin
      o_status.gain_high <= cmp_s.line_high; // R12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  AST_OVP_ENTER: assert property ( // R1
    state == pps_pkg::PPS_RUN && db_done[pps_pkg::DB_OVP] && !sat_trip && !cmp_s.vcc_off
    |=> state == pps_pkg::PPS_OVP ##1 !o_gate_drive && o_status.ovp_active)
    else $error("overvoltage stop not entered");

  AST_OVP_HOLD: assert property ( // R1
    state == pps_pkg::PPS_OVP && !cmp_s.fb_release && !cmp_s.vcc_off
    |=> state == pps_pkg::PPS_OVP && !o_gate_drive)
    else $error("overvoltage stop left before release");

  for (genvar a = 0; a < pps_pkg::DB_N; a++) begin : g_ast
    AST_DB_HELD: assert property ( // R2 R8 R11
      db_done[a] |-> db_cond[a] && $past(db_cond[a]) && db_cnt[a] == db_limit(a))
      else $error("debounce finished without a held cause");
    AST_DB_CLEAR: assert property ( // R14
      !db_cond[a] |=> db_cnt[a] == '0)
      else $error("debounce counter not restarted");
  end

  AST_HV_RECHARGE: assert property ( // R3
    state == pps_pkg::PPS_OVP && cmp_s.vcc_recharge && !cmp_s.fb_release && !cmp_s.vcc_off
    |=> o_status.hv_startup)
    else $error("startup source not enabled during overvoltage");

  AST_PEAK_CUT: assert property ( // R4
    cmp_s.cs_peak |=> !o_gate_drive)
    else $error("gate not cut at peak limit");

  AST_SAT_STOP: assert property ( // R5
    state == pps_pkg::PPS_RUN && sat_trip && !cmp_s.vcc_off
    |=> state == pps_pkg::PPS_SAT && !o_gate_drive)
    else $error("saturation stop missed");

  AST_SAT_HOLD: assert property ( // R6
    state == pps_pkg::PPS_SAT && !cmp_s.cs_zero && !cmp_s.vcc_off
    |=> state == pps_pkg::PPS_SAT && o_status.sat_active)
    else $error("saturation stop left early");

  AST_FB_OPEN: assert property ( // R7
    state == pps_pkg::PPS_CHECK && db_done[pps_pkg::DB_FB_OPEN] && !cmp_s.vcc_off
    |=> o_status.low_power && o_status.fb_fault && !o_gate_drive)
    else $error("open feedback not handled");

  AST_CS_FAIL_HOLD: assert property ( // R10
    state == pps_pkg::PPS_CS_FAIL && !cmp_s.vcc_off |=> state == pps_pkg::PPS_CS_FAIL)
    else $error("sense fault left without supply recycle");

  AST_GAIN: assert property ( // R12
    ##1 o_status.gain_high == $past(cmp_s.line_high))
    else $error("gain select does not follow line comparator");

  AST_VCC_OFF: assert property ( // R13
    cmp_s.vcc_off |=> state == pps_pkg::PPS_OFF && o_status.hv_startup && !o_gate_drive)
    else $error("supply loss not handled");

  COV_OVP: cover property (state == pps_pkg::PPS_OVP ##1 state == pps_pkg::PPS_RUN);
  COV_SAT: cover property (state == pps_pkg::PPS_SAT ##1 state == pps_pkg::PPS_RUN);
  COV_CS_FAIL: cover property (state == pps_pkg::PPS_CS_FAIL ##1 state == pps_pkg::PPS_OFF);
  COV_PEAK: cover property (o_gate_drive ##1 !o_gate_drive && i_pwm_on);

endmodule : pps_protection_sequencer

/* File: verification/pps_stage_model.sv */
// Behavioural comparators around the boost stage: supply, feedback, sense.
// Assumes the bench sets its levels just after a rising edge of the core clock.
`timescale 1ns/1ps
module pps_stage_model (
  input wire logic i_core_clk,
  input wire logic i_gate,
  input wire logic [1:0] i_supply,
  input wire logic [1:0] i_fb,
  input wire logic [7:0] i_peak_at,
  input wire logic i_sat,
  input wire logic i_cs_open,
  input wire logic i_line,
  output pps_pkg::pps_cmp_type o_cmp
);
  // Supply: 0 off, 1 recharge, 2 mid, 3 on. Feedback: 0 open, 1 regulated,
  // 2 above release but below over level, 3 over.
  logic [7:0] on_time;

  // Inductor current ramps only while the switch conducts
  always_ff @(posedge i_core_clk) begin
    on_time <= i_gate ? on_time + 8'h01 : 8'h00;
  end

  // Zero current is withheld while saturated, so the stop cannot clear early
  always_comb begin
    o_cmp.fb_over = (i_fb == 2'h3);
    o_cmp.fb_release = (i_fb <= 2'h1);
    o_cmp.fb_open = (i_fb == 2'h0);
    o_cmp.cs_peak = i_gate && (on_time >= i_peak_at);
    o_cmp.cs_sat = i_gate && i_sat;
    o_cmp.cs_zero = !i_gate && !i_sat;
    o_cmp.cs_open = i_cs_open;
    o_cmp.vcc_on = (i_supply == 2'h3);
    o_cmp.vcc_off = (i_supply == 2'h0);
    o_cmp.vcc_recharge = (i_supply <= 2'h1);
    o_cmp.line_high = i_line;
  end
endmodule : pps_stage_model

/* File: verification/pfc_protection_sequencer_test.sv */
// Self-checking bench for the protection sequencer with a comparator model.
// Assumes the assertions inside the design watch the logic alongside.
`timescale 1ns/1ps
module pfc_protection_sequencer_test;
  localparam int HV = 7, LP = 6, SS = 5, GH = 4, OV = 3, SA = 2, FF = 1, CF = 0;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pwm = 1'b0;
  logic [1:0] supply = 2'h0;
  logic [1:0] fb = 2'h1;
  logic [7:0] peak_at = 8'hff;
  logic sat = 1'b0;
  logic cs_open = 1'b0;
  logic line = 1'b0;
  logic gate;
  pps_pkg::pps_cmp_type cmp;
  pps_pkg::pps_status_type stat;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  int g;

  pps_stage_model i_stage (
    .i_core_clk(clk), .i_gate(gate), .i_supply(supply), .i_fb(fb),
    .i_peak_at(peak_at), .i_sat(sat), .i_cs_open(cs_open), .i_line(line), .o_cmp(cmp)
  );
  // Short overvoltage debounce keeps the run brief; bounds below use 50
  pps_protection_sequencer #(.OVP_DB_CYCLES(50)) i_dut (
    .i_core_clk(clk), .i_sys_rst(rst), .i_cmp(cmp), .i_pwm_on(pwm),
    .o_gate_drive(gate), .o_status(stat)
  );

  initial begin
    forever #2.5 clk = ~clk;
  end

  // Ceiling is about five times the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Leaves the cycles waited in n for timing bounds
  task automatic wait_stat(input int b, input logic v, input int lim);
    n = 0;
    while (stat[b] !== v && n < lim) begin
      tick(1);
      n++;
    end
    chk(8'(stat[b]), 8'(v));
  endtask : wait_stat

  // One modulator on-time; g counts the cycles the gate really conducted
  task automatic pulse(input int on);
    g = 0;
    pwm = 1'b1;
    repeat (on) begin
      tick(1);
      g += int'(gate);
    end
    pwm = 1'b0;
    tick(10);
  endtask : pulse

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    tick(8);
    chk(8'(gate), 8'h00);
    chk(stat, 8'h80);
    rst = 1'b0;
    tick(2);
    chk(stat, 8'h80);
    done("reset");
  endtask : t_reset

  task automatic t_startup();
    supply = 2'h3;
    wait_stat(SS, 1'b1, 4100);
    tick(1);
    chk(8'(stat[HV]), 8'h00);
    pulse(20);
    chk(8'(g >= 18), 8'h01);
    done("startup");
  endtask : t_startup

  task automatic t_peak();
    peak_at = 8'h05;
    pulse(30);
    chk(8'(g >= 3 && g <= 12), 8'h01);
    peak_at = 8'hff;
    pulse(30);
    chk(8'(g >= 28), 8'h01);
    done("peak");
  endtask : t_peak

  task automatic t_sat();
    sat = 1'b1;
    pulse(20);
    sat = 1'b0;
    pulse(20);
    sat = 1'b1;
    pulse(20);
    chk(8'(stat[SA]), 8'h00);
    pulse(20);
    chk(8'(g <= 6), 8'h01);
    wait_stat(SA, 1'b1, 1);
    pulse(20);
    chk(8'(g), 8'h00);
    sat = 1'b0;
    wait_stat(SA, 1'b0, 8);
    pulse(20);
    chk(8'(g >= 18), 8'h01);
    done("saturation");
  endtask : t_sat

  task automatic t_ovp();
    fb = 2'h3;
    tick(30);
    fb = 2'h1;
    tick(40);
    chk(8'(stat[OV]), 8'h00);
    fb = 2'h3;
    wait_stat(OV, 1'b1, 70);
    chk(8'(n >= 50 && n <= 60), 8'h01);
    pulse(20);
    chk(8'(g), 8'h00);
    fb = 2'h2;
    tick(20);
    chk(8'(stat[OV]), 8'h01);
    supply = 2'h1;
    wait_stat(HV, 1'b1, 6);
    supply = 2'h2;
    tick(10);
    chk(8'(stat[HV]), 8'h01);
    supply = 2'h3;
    wait_stat(HV, 1'b0, 6);
    fb = 2'h1;
    wait_stat(OV, 1'b0, 6);
    pulse(20);
    chk(8'(g >= 18), 8'h01);
    done("overvoltage");
  endtask : t_ovp

  task automatic t_line();
    line = 1'b1;
    wait_stat(GH, 1'b1, 5);
    line = 1'b0;
    wait_stat(GH, 1'b0, 5);
    done("line");
  endtask : t_line

  task automatic t_cs_fail();
    supply = 2'h0;
    wait_stat(HV, 1'b1, 6);
    chk(8'(gate), 8'h00);
    cs_open = 1'b1;
    supply = 2'h3;
    wait_stat(CF, 1'b1, 4100);
    chk(8'(n >= 2000), 8'h01);
    chk(8'(stat[LP]), 8'h01);
    cs_open = 1'b0;
    supply = 2'h2;
    tick(10);
    supply = 2'h3;
    tick(50);
    chk(8'(stat[CF]), 8'h01);
    pulse(20);
    chk(8'(g), 8'h00);
    supply = 2'h0;
    tick(10);
    supply = 2'h3;
    wait_stat(SS, 1'b1, 4100);
    chk(8'(stat[CF]), 8'h00);
    done("sense_fail");
  endtask : t_cs_fail

  task automatic t_fb_open();
    supply = 2'h0;
    tick(10);
    fb = 2'h0;
    supply = 2'h3;
    wait_stat(FF, 1'b1, 4100);
    chk(8'(n >= 360), 8'h01);
    chk(8'(stat[LP]), 8'h01);
    pulse(20);
    chk(8'(g), 8'h00);
    fb = 2'h1;
    wait_stat(FF, 1'b0, 8);
    pulse(20);
    chk(8'(g >= 18), 8'h01);
    done("feedback_open");
  endtask : t_fb_open

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    t_reset();
    t_startup();
    t_peak();
    t_sat();
    t_ovp();
    t_line();
    t_cs_fail();
    t_fb_open();
    give_verdict();
  end
endmodule : pfc_protection_sequencer_test
